/* coproc_port_pkg.sv */
package coproc_port_pkg;
  // Coprocessor I/O port byte addresses
  localparam logic [15:0] PORT_OPCODE_CTRL = 16'h00F8;
  localparam logic [15:0] PORT_DATA = 16'h00FA;
  localparam logic [15:0] PORT_POINTER = 16'h00FC;
  localparam logic [15:0] PORT_OPSTATUS = 16'h00FE;
  // Least processor clocks per memory operand transfer
  localparam int OPERAND_XFER_MIN_CLOCKS = 17;
  localparam logic [4:0] OPERAND_XFER_CNT = 5'(OPERAND_XFER_MIN_CLOCKS - 1);
  // Interrupt vector type for coprocessor error
  localparam logic [7:0] ERROR_TRAP_TYPE = 8'h10;
  // Cycle kinds
  typedef enum logic [2:0] {
    CYC_OPCODE_WR, CYC_STATUS_RD, CYC_DATA_WR, CYC_DATA_RD, CYC_POINTER_WR, CYC_OPSTAT_RD
  } cyc_kind_type;
endpackage

/* coproc_host_port.sv */
`timescale 1ns/1ps
// Behaviour
// - Four 16-bit ports: opcode/status, data, pointers, opcode status.
// - Opcode written first, then opcode status word read back.
// - Each memory operand transfer spans at least 17 clocks.
// - Numerics opcode without coprocessor and escape trap clear is undefined.
// - Coprocessor cycles drive control outputs like any I/O cycle.
// - Coprocessor access ends only when bus ready is asserted.
// - Chip-select covering coprocessor ports also goes active on them.
// - Coprocessor select asserts only for coprocessor port accesses.
// - Bus left free between coprocessor cycles for refresh and DMA.
// - Hold granted during numerics when bus unneeded; may stall cycles.
// - Locked numerics instruction keeps lock asserted throughout.
// - Error input sampled only at start of each numerics instruction.
// - Sampled active error takes interrupt type 16 instead.
// - No error check after last instruction; software appends a no-op.
// - Handshake is select, busy, operand request and error.
module coproc_host_port
  import coproc_port_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Core side
  input wire logic insn_start_i,
  input wire logic insn_locked_i,
  input wire logic [15:0] insn_opcode_i,
  input wire logic [2:0] insn_operands_i,
  input wire logic insn_store_i,
  input wire logic escape_trap_bit_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic [15:0] pointer_data_i,
  output logic insn_done_o,
  output logic trap_o,
  output logic [7:0] trap_type_o,
  output logic escape_trap_o,
  output logic [15:0] opcode_status_o,
  output logic [15:0] store_data_o,
  output logic store_valid_o,
  // Chip-select programming for the coprocessor range
  input wire logic [15:0] cs_base_i,
  input wire logic [15:0] cs_limit_i,
  input wire logic cs_io_space_i,
  // Bus side
  input wire logic ready_i,
  input wire logic hold_i,
  output logic hold_acknowledge_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wdata_oe_o,
  input wire logic [15:0] rdata_i,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic transceiver_direction_o,
  output logic data_buffer_enable_n_o,
  output logic lock_n_o,
  output logic gcs_n_o,
  output logic coproc_select_n_o,
  // Handshake from the coprocessor
  input wire logic busy_i,
  input wire logic operand_transfer_request_i,
  input wire logic error_n_i
);

  // One instruction walks these steps, taking ST_PTR before ST_WAIT. The check step looks at
  // the escape trap bit and the synchronised error line and may end the
  // instruction at once. Otherwise the opcode write, the opcode status read
  // and the pointer write go out, then the sequencer waits for operand
  // requests. Each data-port cycle is followed by a fixed gap that stands
  // for the memory leg the core performs on the coprocessor's behalf.
  // The instruction ends once no operand is left and busy has dropped.
  // Limitation: operand count comes from the core, not from the partner.
  typedef enum logic [3:0] {
    ST_IDLE, ST_CHECK, ST_OPC, ST_STAT, ST_WAIT, ST_PTR, ST_XFER, ST_GAP, ST_END
  } step_type;

  step_type step;
  logic [1:0] busy_sync, req_sync, err_sync;
  logic bus_active, bus_write, locked, cyc_done;
  logic [15:0] cur_addr;
  logic [2:0] ops_left;
  logic [4:0] gap_cnt;
  logic store_mode;

  // This decode serves the select path only; chip-select compares against its programmed range
  function automatic logic is_coproc_port(input logic [15:0] a);
    return a[15:3] == PORT_OPCODE_CTRL[15:3] && a[0] == 1'b0;
  endfunction

  // Two-stage synchronisers; the partner clock is unrelated
  // Only the second stage is read, so a metastable first stage never
  // reaches the sequencer; the price is two clocks of latency
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_sync <= 2'b00;
      req_sync <= 2'b00;
      err_sync <= 2'b11;
    end else begin
      busy_sync <= {busy_sync[0], busy_i};
      req_sync <= {req_sync[0], operand_transfer_request_i};
      err_sync <= {err_sync[0], error_n_i};
    end
  end

  wire logic busy_s = busy_sync[1];
  wire logic req_s = req_sync[1];
  wire logic err_active = ~err_sync[1];
  // A cycle finishes only on ready, like any I/O cycle
  assign cyc_done = bus_active & ready_i;

  // Instruction sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step <= ST_IDLE;
      ops_left <= 3'h0;
      gap_cnt <= 5'h00;
      store_mode <= 1'b0;
      locked <= 1'b0;
      trap_o <= 1'b0;
      escape_trap_o <= 1'b0;
      insn_done_o <= 1'b0;
    end else begin
      trap_o <= 1'b0;
      escape_trap_o <= 1'b0;
      insn_done_o <= 1'b0;
      unique case (step)
        // Start is only taken here; a start while busy is ignored
        // Lock and direction are frozen for the whole instruction
        ST_IDLE: if (insn_start_i) begin
          ops_left <= insn_operands_i;
          store_mode <= insn_store_i;
          locked <= insn_locked_i;
          step <= ST_CHECK;
        end
        ST_CHECK: begin
          // Error is looked at here only, so a fault shows on the next instruction
          if (escape_trap_bit_i) begin
            escape_trap_o <= 1'b1;
            locked <= 1'b0;
            step <= ST_IDLE;
          end else if (err_active) begin
            trap_o <= 1'b1;
            locked <= 1'b0;
            step <= ST_IDLE;
          end else begin
            step <= ST_OPC;
          end
        end
        ST_OPC: begin
          // Opcode goes out before anything else of the instruction
          if (cyc_done) begin
            step <= ST_STAT;
          end
        end
        ST_STAT: begin
          // Opcode status word comes back on the next cycle
          if (cyc_done) begin
            step <= ST_PTR;
          end
        end
        ST_PTR: begin
          // Instruction and operand pointers follow the status read
          if (cyc_done) begin
            step <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Bus is idle here, free for refresh, DMA and hold
          if (ops_left != 3'h0 && req_s) begin
            step <= ST_XFER;
          end else if (ops_left == 3'h0 && !busy_s) begin
            step <= ST_END;
          end
        end
        // One data-port cycle per operand, then the gap counter is loaded
        ST_XFER: if (cyc_done) begin
          ops_left <= ops_left - 3'h1;
          gap_cnt <= OPERAND_XFER_CNT;
          step <= ST_GAP;
        end
        ST_GAP: begin
          // Models the memory leg; keeps each operand at 17 clocks or more
          // The request is ignored here, so a fast partner cannot shorten it
          if (gap_cnt == 5'h00) begin
            step <= ST_WAIT;
          end else begin
            gap_cnt <= gap_cnt - 5'h01;
          end
        end
        ST_END: begin
          // No error look here: a fault of the last instruction waits for
          // the next numerics instruction, so software appends a no-op
          insn_done_o <= 1'b1;
          locked <= 1'b0;
          step <= ST_IDLE;
        end
      endcase
    end
  end

  wire logic want_bus = step == ST_OPC || step == ST_STAT || step == ST_PTR ||
                        step == ST_XFER;

  // Hold arbitration: grant between bus cycles unless locked
  // A pending coprocessor cycle does not block the grant; launch already
  // waits for hold to go away, so refusing here would deadlock both sides.
  // The trade-off is that alternate masters may stall the instruction
  // for as long as they keep hold up.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_acknowledge_o <= 1'b0;
    end else if (hold_acknowledge_o) begin
      hold_acknowledge_o <= hold_i;
    end else begin
      hold_acknowledge_o <= hold_i & ~bus_active & ~locked;
    end
  end

  // Bus cycle launch: one cycle per step, held until ready
  // Address and write data stay registered after the cycle, so the
  // select decode only looks at them while the cycle is active
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_active <= 1'b0;
      bus_write <= 1'b0;
      cur_addr <= 16'h0000;
      wdata_o <= 16'h0000;
    end else if (cyc_done) begin
      bus_active <= 1'b0;
    end else if (!bus_active && want_bus && !hold_acknowledge_o && !hold_i) begin
      bus_active <= 1'b1;
      unique case (step)
        ST_OPC: begin
          cur_addr <= PORT_OPCODE_CTRL;
          bus_write <= 1'b1;
          wdata_o <= insn_opcode_i;
        end
        ST_STAT: begin
          cur_addr <= PORT_OPSTATUS;
          bus_write <= 1'b0;
        end
        ST_PTR: begin
          cur_addr <= PORT_POINTER;
          bus_write <= 1'b1;
          wdata_o <= pointer_data_i;
        end
        default: begin
          cur_addr <= PORT_DATA;
          bus_write <= ~store_mode;
          wdata_o <= mem_rdata_i;
        end
      endcase
    end
  end

  // Read results captured at the ending edge
  // Only the ready edge is used, so wait states never latch a partial word
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opcode_status_o <= 16'h0000;
      store_data_o <= 16'h0000;
      store_valid_o <= 1'b0;
    end else begin
      store_valid_o <= 1'b0;
      if (cyc_done && !bus_write && step == ST_STAT) opcode_status_o <= rdata_i;
      if (cyc_done && !bus_write && step == ST_XFER) begin
        store_data_o <= rdata_i;
        store_valid_o <= 1'b1;
      end
    end
  end

  // Strobes behave as on any I/O cycle; nothing coprocessor specific
  // Buffer enable is not gated with the select here; on a buffered bus
  // that gating belongs to board logic
  assign addr_o = cur_addr;
  assign wdata_oe_o = bus_active & bus_write;
  assign rd_n_o = ~(bus_active & ~bus_write);
  assign wr_n_o = ~(bus_active & bus_write);
  assign transceiver_direction_o = bus_write;
  assign data_buffer_enable_n_o = ~bus_active;
  assign lock_n_o = ~locked;
  assign trap_type_o = ERROR_TRAP_TYPE;
  // General chip-select still fires if its range covers the ports
  assign gcs_n_o = ~(bus_active & cs_io_space_i & cur_addr >= cs_base_i &&
                     cur_addr <= cs_limit_i);
  // Select is decoded from the address alone; programming cannot reach it
  assign coproc_select_n_o = ~(bus_active & is_coproc_port(cur_addr));

endmodule

/* coproc_host_port_properties.sv */
`timescale 1ns/1ps
module coproc_host_port_properties (
  input wire logic sys_clk_i, rst_n_i, ready_i, cs_io_space_i,
  input wire logic [15:0] cs_base_i, cs_limit_i, addr_o,
  input wire logic rd_n_o, wr_n_o, wdata_oe_o, transceiver_direction_o,
  input wire logic data_buffer_enable_n_o, lock_n_o, gcs_n_o, coproc_select_n_o,
  input wire logic hold_acknowledge_o, trap_o,
  input wire logic [7:0] trap_type_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_sel; !coproc_select_n_o |-> addr_o[15:3] == 13'h001F; endproperty
  a_sel: assert property (p_sel) else $error("select off port");
  property p_dir; !wr_n_o |-> transceiver_direction_o && wdata_oe_o && !data_buffer_enable_n_o;
  endproperty
  a_dir: assert property (p_dir) else $error("write strobes");
  property p_rdy; !coproc_select_n_o && !ready_i |=> !coproc_select_n_o && $stable(addr_o);
  endproperty
  a_rdy: assert property (p_rdy) else $error("cycle ended early");
  property p_gcs; !coproc_select_n_o && cs_io_space_i && addr_o >= cs_base_i
    && addr_o <= cs_limit_i |-> !gcs_n_o; endproperty
  a_gcs: assert property (p_gcs) else $error("chip select idle");
  property p_hld; hold_acknowledge_o |-> rd_n_o && wr_n_o && coproc_select_n_o; endproperty
  a_hld: assert property (p_hld) else $error("bus used in hold");
  property p_lck; !lock_n_o |-> !hold_acknowledge_o; endproperty
  a_lck: assert property (p_lck) else $error("hold while locked");
  property p_trp; trap_o |-> trap_type_o == 8'h10 && coproc_select_n_o; endproperty
  a_trp: assert property (p_trp) else $error("bad trap");
  // Only eight cycles of the gap are watched, the repetition limit
  property p_gap; $rose(coproc_select_n_o) && addr_o == 16'h00FA |->
    (coproc_select_n_o || addr_o != 16'h00FA) [*8]; endproperty
  a_gap: assert property (p_gap) else $error("operand gap short");
endmodule
bind coproc_host_port coproc_host_port_properties u_props (.*);

/* coproc_model.sv */
`timescale 1ns/1ps
module coproc_model
  import coproc_port_pkg::*;
#(parameter logic [15:0] STATUS = 16'h5A3C, parameter logic [15:0] DATA = 16'h0C3D) (
  input wire logic clk_i, rst_n_i, sel_n_i, rd_n_i, wr_n_i, slow_i, err_i,
  input wire logic [15:0] addr_i,
  input wire logic [2:0] ops_i,
  output logic ready_o, busy_o, req_o, error_n_o,
  output logic [15:0] rdata_o
);
  logic [1:0] waits;
  logic [2:0] rem;
  logic [15:0] last;
  wire take = !sel_n_i && ready_o;
  // Slow mode stretches every cycle by three wait states
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) waits <= 2'h0;
    else waits <= (sel_n_i || ready_o) ? 2'h0 : waits + 2'h1;
  end
  assign ready_o = !sel_n_i && (!slow_i || waits == 2'h3);
  // Busy from opcode write until the last operand has moved
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      rem <= 3'h0;
    end else if (take && !wr_n_i && addr_i == PORT_OPCODE_CTRL) begin
      busy_o <= 1'b1;
      rem <= ops_i;
    end else if (take && addr_i == PORT_DATA) rem <= rem - 3'h1;
    else if (rem == 3'h0) busy_o <= 1'b0;
  end
  assign req_o = busy_o && rem != 3'h0;
  // Error goes straight to the host; no external busy latch is modelled
  assign error_n_o = !err_i;
  // Released lines toggle each cycle so a stale word never passes for a read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) last <= 16'h0000;
    else last <= rdata_o;
  end
  // Data only driven while selected, as a select-gated buffer would allow
  assign rdata_o = (!sel_n_i && !rd_n_i) ? (addr_i == PORT_OPSTATUS ? STATUS :
    addr_i == PORT_OPCODE_CTRL ? 16'h0300 : DATA) : ~last;
endmodule

/* math_coprocessor_host_port_test.sv */
`timescale 1ns/1ps
module math_coprocessor_host_port_test;
  import coproc_port_pkg::*;
  // Fields: locked, store, escape, error, slow, operands, expected done/trap/escape
  typedef struct packed {logic [4:0] f; logic [2:0] ops; logic [2:0] exp;} row_type;
  localparam logic [15:0] STAT = 16'h5A3C;
  localparam logic [15:0] DAT = 16'h0C3D;
  logic sys_clk_i, rst_n_i, start, lk, st, et, er, sl, hold, late, rdy, busy, req, err_n;
  logic rd_n, wr_n, sel_n, done, trap, etrap, hack, lock_n;
  logic [2:0] ops, got;
  logic [15:0] word, addr, rdata, sd, ost;
  int n_mismatch = 0;
  int checks = 0;
  row_type rows [6] = '{11'h004, 11'h054, 11'h20C, 11'h101, 11'h082, 11'h45C};
  coproc_host_port u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .insn_start_i(start),
    .insn_locked_i(lk), .insn_opcode_i(word), .insn_operands_i(ops), .insn_store_i(st),
    .escape_trap_bit_i(et), .mem_rdata_i(word), .pointer_data_i(word), .insn_done_o(done),
    .trap_o(trap), .trap_type_o(), .escape_trap_o(etrap), .opcode_status_o(ost),
    .store_data_o(sd), .store_valid_o(), .cs_base_i(PORT_OPCODE_CTRL), .cs_limit_i(16'h00FF),
    .cs_io_space_i(1'b1), .ready_i(rdy), .hold_i(hold), .hold_acknowledge_o(hack),
    .addr_o(addr), .wdata_o(), .wdata_oe_o(), .rdata_i(rdata), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .transceiver_direction_o(), .data_buffer_enable_n_o(), .lock_n_o(lock_n), .gcs_n_o(),
    .coproc_select_n_o(sel_n), .busy_i(busy), .operand_transfer_request_i(req),
    .error_n_i(err_n));
  coproc_model #(.STATUS(STAT), .DATA(DAT)) u_model (.clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .sel_n_i(sel_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .slow_i(sl), .err_i(er), .addr_i(addr),
    .ops_i(ops), .ready_o(rdy), .busy_o(busy), .req_o(req), .error_n_o(err_n),
    .rdata_o(rdata));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task tick;
    @(posedge sys_clk_i);
    #2;
  endtask
  // Hold is raised mid-instruction: granted unless the instruction is locked
  task run(input row_type r);
    int i;
    {lk, st, et, er, sl} = r.f;
    ops = r.ops;
    word = word + 16'h1111;
    repeat (4) tick;
    start = 1'b1;
    tick;
    start = 1'b0;
    got = 3'h0;
    for (i = 0; i < 400 && got == 3'h0; i++) begin
      if (i == 2) hold = 1'b1;
      if (i == 3 && late) er = 1'b1;
      if (i == 4) check({15'h0, lock_n}, {15'h0, !lk});
      if (i == 10) check({15'h0, hack}, {15'h0, !lk});
      if (i == 10) hold = 1'b0;
      tick;
      got = {done, trap, etrap};
    end
    hold = 1'b0;
    check({13'h0, got}, {13'h0, r.exp});
    if (r.exp[2]) check(ost, STAT);
    if (st) check(sd, DAT);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // Whole run takes a few hundred cycles; the limit of 40000 cycles lies far above that
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    {rst_n_i, start, hold, late, lk, st, et, er, sl, ops} = 12'h000;
    word = 16'h1357;
    repeat (12) @(posedge sys_clk_i);
    #2 rst_n_i = 1'b1;
    foreach (rows[k]) run(rows[k]);
    // Error raised after the start check waits for the next instruction
    late = 1'b1;
    run(rows[1]);
    late = 1'b0;
    run(rows[4]);
    // Reset in mid-instruction, between the opcode write and the status read, leaves every strobe off
    er = 1'b0;
    repeat (4) tick;
    start = 1'b1;
    tick;
    start = 1'b0;
    repeat (3) tick;
    rst_n_i = 1'b0;
    #1 check({12'h0, rd_n, wr_n, sel_n, hack}, 16'h000E);
    repeat (2) tick;
    rst_n_i = 1'b1;
    run(rows[2]);
    give_verdict;
  end
endmodule
